// ===== pttl_regs.sv
// Function
// - sixteen per-port target id registers at 0x100 stride from 0x16028
// - high byte used only when wide select is set
// - narrow mode: 8-bit destination id from low-byte field
// - wide mode: 16-bit id, high byte over low byte
// - 16-bit lifetime limit per port
// - limit zero disables lifetime supervision
// - expiry between 78 and 117 bus periods times limit
// - lifetime timebase is the register-bus clock
// - expiry discards packet and sets egress drop flag
// - expiry may raise an error-report port-write
// - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module pttl_regs
  import pttl_pkg::*;
#(
  parameter int unsigned PORTS = pttl_pkg::NPORTS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // register port
  input  wire logic [19:0]        addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output var  logic [31:0]        rdata_q,
  // packet supervision, one slot per port
  input  wire logic [PORTS-1:0]   pkt_start,
  input  wire logic [PORTS-1:0]   pkt_done,
  output var  logic [PORTS-1:0]   pkt_drop_q,
  output var  logic [PORTS-1:0]   drop_flag_q,
  // port-write request for error reports
  output var  logic               pw_req_q,
  output var  logic [3:0]         pw_port_q,
  output var  logic [15:0]        pw_destid_q,
  output var  logic               pw_wide_q
);
  import pttl_pkg::*;

  typedef enum logic [0:0] {PTTL_IDLE = 1'b0, PTTL_LIVE = 1'b1} pttl_slot_e;

  // ==========================================================================
  // address decode
  function automatic logic hit(input logic [19:0] a, input logic [19:0] base, input int unsigned p);
    hit = (a == base + 20'(p) * PORT_STRIDE);
  endfunction : hit

  // destination id from a target register
  function automatic logic [15:0] destid(input logic [31:0] r);
    if (r[WIDE_BIT])
      destid = {r[HI_LSB+:8], r[LO_LSB+:8]};
    else
      destid = {8'h00, r[LO_LSB+:8]};
  endfunction : destid

  logic [31:0]      tgt_q [PORTS];
  logic [31:0]      ttl_q [PORTS];
  logic [PORTS-1:0] tick;
  logic [PORTS-1:0] expire;
  logic [23:0]      live0_q;

  // ==========================================================================
  // timebase
  // each slot runs its own divider of TICK_CYC bus clocks, restarted when a
  // packet enters; a shared free-running divider would add up to one whole
  // unit of phase error, too much for the lower bound at small limits

  // ==========================================================================
  // per-port registers and lifetime counters
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      pttl_slot_e  st_q;
      logic [6:0]  sub_q;
      logic [15:0] age_q;
      logic [15:0] lim;

      assign lim     = ttl_q[p][TTL_W-1:0];
      // one-cycle enable at the end of each lifetime unit of this slot
      assign tick[p] = (st_q == PTTL_LIVE) && (sub_q == TICK_LAST);

      always_ff @(posedge clk) begin
        if (srst) begin
          tgt_q[p] <= RST_VAL;
          ttl_q[p] <= RST_VAL;
        end else if (wr) begin
          if (hit(addr, TGT_BASE, p))
            tgt_q[p] <= wdata & TGT_MASK;
          else if (hit(addr, TTL_BASE, p))
            ttl_q[p] <= wdata & TTL_MASK;
        end
      end

      // the unit just ending completes the limit: expiry lands at limit*TICK_CYC
      // bus clocks after entry, inside the allowed window for every nonzero limit
      assign expire[p] = tick[p] && !pkt_done[p] &&
                         (lim != 16'h0000) &&
                         (age_q >= lim - 16'h0001);

      // slot state: one tracked packet at a time, a new start is ignored while live
      always_ff @(posedge clk) begin
        if (srst) begin
          st_q <= PTTL_IDLE;
        end else begin
          case (st_q)
            PTTL_IDLE: begin
              if (pkt_start[p]) begin
                st_q <= PTTL_LIVE;
              end
            end
            PTTL_LIVE: begin
              if (pkt_done[p] || expire[p]) begin
                st_q <= PTTL_IDLE;
              end
            end
            default: begin
              st_q <= PTTL_IDLE;
            end
          endcase
        end
      end

      // unit divider
      always_ff @(posedge clk) begin
        if (srst) begin
          sub_q <= 7'h00;
        end else if (st_q != PTTL_LIVE) begin
          sub_q <= 7'h00;
        end else if (sub_q == TICK_LAST) begin
          sub_q <= 7'h00;
        end else begin
          sub_q <= sub_q + 7'h01;
        end
      end

      // completed lifetime units, saturating
      always_ff @(posedge clk) begin
        if (srst) begin
          age_q <= 16'h0000;
        end else if (st_q != PTTL_LIVE) begin
          age_q <= 16'h0000;
        end else if (tick[p] && age_q != 16'hffff) begin
          age_q <= age_q + 16'h0001;
        end
      end

      sub_range_a: assert property (@(posedge clk) disable iff (srst)
        sub_q <= TICK_LAST)
        else $error("unit divider out of range");
      start_live_a: assert property (@(posedge clk) disable iff (srst)
        st_q == PTTL_IDLE && pkt_start[p] |=> st_q == PTTL_LIVE && age_q == 16'h0000)
        else $error("packet start not taken");
      done_idle_a: assert property (@(posedge clk) disable iff (srst)
        st_q == PTTL_LIVE && pkt_done[p] |=> st_q == PTTL_IDLE && !pkt_drop_q[p])
        else $error("finished packet still tracked");

      always_ff @(posedge clk) begin
        if (srst) begin
          pkt_drop_q[p]  <= 1'b0;
          drop_flag_q[p] <= 1'b0;
        end else begin
          pkt_drop_q[p] <= expire[p];
          // set wins over a clear in the same cycle
          if (expire[p])
            drop_flag_q[p] <= 1'b1;
          else if (wr && addr == STAT_BASE + 20'(p) * PORT_STRIDE && wdata[DROP_BIT])
            drop_flag_q[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // error report: lowest expiring port wins; others still flag their drop
  always_ff @(posedge clk) begin
    if (srst) begin
      pw_req_q    <= 1'b0;
      pw_port_q   <= 4'h0;
      pw_destid_q <= 16'h0000;
      pw_wide_q   <= 1'b0;
    end else begin
      pw_req_q <= |expire;
      for (int i = PORTS - 1; i >= 0; i--) begin
        if (expire[i]) begin
          pw_port_q   <= 4'(i);
          pw_destid_q <= destid(tgt_q[i]);
          pw_wide_q   <= tgt_q[i][WIDE_BIT];
        end
      end
    end
  end

  // ==========================================================================
  // read port: unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= RST_VAL;
    end else begin
      rdata_q <= RST_VAL;
      if (rd) begin
        for (int i = 0; i < PORTS; i++) begin
          if (hit(addr, TGT_BASE, i))
            rdata_q <= tgt_q[i];
          else if (hit(addr, TTL_BASE, i))
            rdata_q <= ttl_q[i];
          else if (hit(addr, STAT_BASE, i))
            rdata_q <= {31'h0, drop_flag_q[i]};
        end
      end
    end
  end

  // ==========================================================================
  // checks
  // port 0 live-cycle count, kept only for the lifetime window checks
  always_ff @(posedge clk) begin
    if (srst) begin
      live0_q <= 24'h000000;
    end else if (g_port[0].st_q != PTTL_LIVE) begin
      live0_q <= 24'h000000;
    end else if (live0_q != 24'hffffff) begin
      live0_q <= live0_q + 24'h000001;
    end
  end

  // ==========================================================================
  // register checks
  tgt_rsvd_a: assert property (@(posedge clk) disable iff (srst)
    (tgt_q[0] & ~TGT_MASK) == 32'h0)
    else $error("target reserved bits set");
  ttl_rsvd_a: assert property (@(posedge clk) disable iff (srst)
    (ttl_q[0] & ~TTL_MASK) == 32'h0)
    else $error("lifetime reserved bits set");
  tgt_p15_rsvd_a: assert property (@(posedge clk) disable iff (srst)
    (tgt_q[15] & ~TGT_MASK) == 32'h0)
    else $error("last target reserved bits set");
  ttl_p15_rsvd_a: assert property (@(posedge clk) disable iff (srst)
    (ttl_q[15] & ~TTL_MASK) == 32'h0)
    else $error("last lifetime reserved bits set");
  write_tgt_a: assert property (@(posedge clk) disable iff (srst)
    wr && addr == TGT_BASE |=> tgt_q[0] == ($past(wdata) & TGT_MASK))
    else $error("target write lost");
  ttl_wr_a: assert property (@(posedge clk) disable iff (srst)
    wr && addr == TTL_BASE |=> ttl_q[0] == ($past(wdata) & TTL_MASK))
    else $error("lifetime write lost");
  tgt_last_a: assert property (@(posedge clk) disable iff (srst)
    wr && addr == TGT_BASE + 20'hf00 |=> tgt_q[15] == ($past(wdata) & TGT_MASK))
    else $error("last target write lost");
  ttl_last_a: assert property (@(posedge clk) disable iff (srst)
    wr && addr == TTL_BASE + 20'hf00 |=> ttl_q[15] == ($past(wdata) & TTL_MASK))
    else $error("last lifetime write lost");
  tgt_hold_a: assert property (@(posedge clk) disable iff (srst)
    !wr |=> tgt_q[0] == $past(tgt_q[0]))
    else $error("target changed without write");
  ttl_hold_a: assert property (@(posedge clk) disable iff (srst)
    !wr |=> ttl_q[0] == $past(ttl_q[0]))
    else $error("lifetime changed without write");
  rd_tgt_a: assert property (@(posedge clk) disable iff (srst)
    rd && addr == TGT_BASE |=> rdata_q == $past(tgt_q[0]))
    else $error("target read wrong");
  rd_ttl_a: assert property (@(posedge clk) disable iff (srst)
    rd && addr == TTL_BASE |=> rdata_q == $past(ttl_q[0]))
    else $error("lifetime read wrong");
  rd_stat_a: assert property (@(posedge clk) disable iff (srst)
    rd && addr == STAT_BASE |=> rdata_q == {31'h0, $past(drop_flag_q[0])})
    else $error("drop flag read wrong");
  rd_unmapped_a: assert property (@(posedge clk) disable iff (srst)
    rd && addr == TGT_BASE - 20'h4 |=> rdata_q == 32'h0)
    else $error("unmapped read not zero");
  rd_idle_a: assert property (@(posedge clk) disable iff (srst)
    !rd |=> rdata_q == 32'h0)
    else $error("read data outside read cycle");

  // ==========================================================================
  // lifetime checks
  ttl_off_a: assert property (@(posedge clk) disable iff (srst)
    ttl_q[0] == 32'h0 |-> !expire[0])
    else $error("expiry with supervision off");
  tick_gap_a: assert property (@(posedge clk) disable iff (srst)
    tick[0] |=> !tick[0] [*8])
    else $error("timebase ticks too close");
  expire_min_a: assert property (@(posedge clk) disable iff (srst)
    expire[0] |-> live0_q >= 78 * ttl_q[0][TTL_W-1:0])
    else $error("packet expired too early");
  expire_max_a: assert property (@(posedge clk) disable iff (srst)
    expire[0] |-> live0_q <= 117 * ttl_q[0][TTL_W-1:0])
    else $error("packet expired too late");
  drop_pulse_a: assert property (@(posedge clk) disable iff (srst)
    expire[0] |=> pkt_drop_q[0] && drop_flag_q[0])
    else $error("expiry did not drop and flag");
  flag_set_a: assert property (@(posedge clk) disable iff (srst)
    expire[15] |=> pkt_drop_q[15] && drop_flag_q[15])
    else $error("last port expiry did not flag");
  drop_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !expire[0] |=> !pkt_drop_q[0])
    else $error("drop without expiry");
  drop_hold_a: assert property (@(posedge clk) disable iff (srst)
    drop_flag_q[0] && !(wr && addr == STAT_BASE) |=> drop_flag_q[0])
    else $error("drop flag lost");
  drop_clear_a: assert property (@(posedge clk) disable iff (srst)
    wr && addr == STAT_BASE && wdata[DROP_BIT] && !expire[0] |=> !drop_flag_q[0])
    else $error("drop flag not cleared");

  // ==========================================================================
  // error report checks
  report_a: assert property (@(posedge clk) disable iff (srst)
    |expire |=> pw_req_q)
    else $error("no error report after expiry");
  pw_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !(|expire) |=> !pw_req_q)
    else $error("error report without expiry");
  narrow_id_a: assert property (@(posedge clk) disable iff (srst)
    expire == 16'h0001 && !tgt_q[0][WIDE_BIT] |=> pw_destid_q == {8'h00, $past(tgt_q[0][LO_LSB+:8])})
    else $error("narrow destination id wrong");
  narrow_hi_a: assert property (@(posedge clk) disable iff (srst)
    pw_req_q && !pw_wide_q |-> pw_destid_q[15:8] == 8'h00)
    else $error("narrow id has upper byte");
  wide_id_a: assert property (@(posedge clk) disable iff (srst)
    expire == 16'h0001 && tgt_q[0][WIDE_BIT] |=>
      pw_destid_q == {$past(tgt_q[0][HI_LSB+:8]), $past(tgt_q[0][LO_LSB+:8])} && pw_wide_q)
    else $error("wide destination id wrong");
  wide_sel_a: assert property (@(posedge clk) disable iff (srst)
    expire == 16'h0001 |=> pw_wide_q == $past(tgt_q[0][WIDE_BIT]))
    else $error("width select not followed");
  pw_port0_a: assert property (@(posedge clk) disable iff (srst)
    expire[0] |=> pw_port_q == 4'h0)
    else $error("report port not lowest");
  pw_port_a: assert property (@(posedge clk) disable iff (srst)
    expire == 16'h8000 |=> pw_port_q == 4'hf)
    else $error("report port wrong");

  // ==========================================================================
  // main scenarios
  expire_c:   cover property (@(posedge clk) |expire);
  wide_c:     cover property (@(posedge clk) pw_req_q && pw_wide_q);
  narrow_c:   cover property (@(posedge clk) pw_req_q && !pw_wide_q);
  done_c:     cover property (@(posedge clk) pkt_done[0] && g_port[0].st_q == PTTL_LIVE);
  zero_lim_c: cover property (@(posedge clk) g_port[0].st_q == PTTL_LIVE && ttl_q[0] == 32'h0);
endmodule : pttl_regs
`default_nettype wire

// ===== pttl_pkg.sv
package pttl_pkg;
  // ==========================================================================
  // register map
  localparam int unsigned NPORTS         = 16;
  localparam logic [19:0] TGT_BASE       = 20'h16028;
  localparam logic [19:0] TTL_BASE       = 20'h1602c;
  localparam logic [19:0] PORT_STRIDE    = 20'h00100;
  localparam logic [19:0] STAT_BASE      = 20'h16030;
  // ==========================================================================
  // field layout
  localparam int unsigned HI_LSB         = 0;
  localparam int unsigned LO_LSB         = 8;
  localparam int unsigned WIDE_BIT       = 16;
  localparam int unsigned TTL_W          = 16;
  localparam logic [31:0] TGT_MASK       = 32'h0001ffff;
  localparam logic [31:0] TTL_MASK       = 32'h0000ffff;
  localparam logic [31:0] RST_VAL        = 32'h00000000;
  localparam int unsigned DROP_BIT       = 0;
  // ==========================================================================
  // timing: one tick per lifetime unit of 96 bus periods (inside 78..117)
  localparam int unsigned BUS_CLK_NS     = 20;
  localparam int unsigned TICK_PERIODS   = 96;
  localparam int unsigned TICK_CYC       = (TICK_PERIODS * BUS_CLK_NS) / BUS_CLK_NS;
  localparam logic [6:0]  TICK_LAST      = 7'(TICK_CYC - 1);
endpackage : pttl_pkg

// ===== pttl_src.sv
`timescale 1ns/1ps
`default_nettype none
module pttl_src (
  // clock
  input  wire logic        clk,
  // commands from the bench
  input  wire logic        fire,
  input  wire logic        retire,
  input  wire logic [3:0]  port,
  // supervision strobes toward the block
  output var  logic [15:0] pkt_start = '0,
  output var  logic [15:0] pkt_done = '0
);
  // ==========================================
  // one-cycle strobes; the bench keeps one packet per port in flight
  always_ff @(posedge clk) begin
    pkt_start <= fire ? 16'h0001 << port : 16'h0000;
    pkt_done  <= retire ? 16'h0001 << port : 16'h0000;
  end
endmodule : pttl_src
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pttl_pkg::*;
  // ==========================================
  // signals
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0, retire = 1'b0;
  logic [19:0] addr = '0;
  logic [31:0] wdata = '0, rdata_q, v, r;
  logic [15:0] pkt_start, pkt_done, pkt_drop_q, drop_flag_q, pw_destid_q, lim;
  logic [3:0]  port = '0, pw_port_q;
  logic        pw_req_q, pw_wide_q;
  integer      seed = 32'h8d9e0cc2, err_total = 0, compares = 0, n;
  always #10 clk = ~clk;
  pttl_regs pttl_regs_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .pkt_start(pkt_start), .pkt_done(pkt_done), .pkt_drop_q(pkt_drop_q),
    .drop_flag_q(drop_flag_q), .pw_req_q(pw_req_q), .pw_port_q(pw_port_q),
    .pw_destid_q(pw_destid_q), .pw_wide_q(pw_wide_q));
  pttl_src pttl_src_i (.clk(clk), .fire(fire), .retire(retire), .port(port),
    .pkt_start(pkt_start), .pkt_done(pkt_done));
  // ==========================================
  // helpers
  task automatic give_verdict;
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [19:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // data stand only in the cycle after the strobe
  task automatic rreg(input logic [19:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata_q;
    @(posedge clk);
  endtask : rreg
  function automatic logic [15:0] exp_id(input logic [31:0] t);
    return t[WIDE_BIT] ? {t[HI_LSB+:8], t[LO_LSB+:8]} : {8'h00, t[LO_LSB+:8]};
  endfunction : exp_id
  // limits from 1, the tightest window, up to 13
  task automatic age(input logic [3:0] p, input logic [31:0] tgt);
    lim = 16'(1 + ($unsigned($random(seed)) % 13));
    wreg(TGT_BASE + PORT_STRIDE * p, tgt);
    wreg(TTL_BASE + PORT_STRIDE * p, {16'h0000, lim});
    port <= p;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    n = 0;
    while (pkt_drop_q[p] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n >= 78 * lim && n <= 117 * lim), 32'h1);
    chk({31'h0, pw_req_q}, 32'h1);
    chk({16'h0, pw_destid_q}, {16'h0, exp_id(tgt)});
    chk({31'h0, pw_wide_q}, {31'h0, tgt[WIDE_BIT]});
    chk({28'h0, pw_port_q}, {28'h0, p});
    chk({16'h0, drop_flag_q}, {16'h0, 16'h0001 << p});
    wreg(STAT_BASE + PORT_STRIDE * p, 32'h1);
    rreg(STAT_BASE + PORT_STRIDE * p, r);
    chk(r, 32'h0);
  endtask : age
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rreg(TGT_BASE, r);
    chk(r, RST_VAL);
    rreg(TTL_BASE + 20'hf00, r);
    chk(r, RST_VAL);
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      wreg(TGT_BASE + PORT_STRIDE * 20'(i), v);
      wreg(TTL_BASE + PORT_STRIDE * 20'(i), ~v);
      rreg(TGT_BASE + PORT_STRIDE * 20'(i), r);
      chk(r, v & TGT_MASK);
      rreg(TTL_BASE + PORT_STRIDE * 20'(i), r);
      chk(r, ~v & TTL_MASK);
    end
    rreg(TGT_BASE - 20'h4, r);
    chk(r, 32'h0);
    age(4'h0, 32'hfffe_a55a);
    age(4'hf, $random(seed) | 32'h0001_0000);
    wreg(TTL_BASE, 32'h0);
    port <= 4'h0;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    v = 0;
    repeat (1000) begin
      @(posedge clk);
      #1 v = v | {16'h0, pkt_drop_q};
    end
    chk(v, 32'h0);
    @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    wreg(TTL_BASE, 32'h3);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (40) @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    v = 0;
    repeat (400) begin
      @(posedge clk);
      #1 v = v | {16'h0, pkt_drop_q};
    end
    chk(v, 32'h0);
    give_verdict();
  end
  // the run needs at most about 4100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
